/* File: rtl/cal_divider.sv */
// unsigned restoring divider, one quotient bit per cycle
// assumes start only while idle; divide by zero yields all ones
`timescale 1ns/1ps
`default_nettype none
module cal_divider #(
	parameter int W = 24
)(
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	// request
	input  wire logic         start,
	input  wire logic [W-1:0] dividend,
	input  wire logic [W-1:0] divisor,
	// result
	output logic              busy,
	output logic              done,
	output logic      [W-1:0] quotient
);
	localparam int CW = $clog2(W + 1);
	logic [W:0]    rem;
	logic [CW-1:0] cnt;
	wire  [W:0]    trial = {rem[W-1:0], quotient[W-1]} - {1'b0, divisor};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			rem      <= '0;
			quotient <= '0;
			cnt      <= '0;
			busy     <= 1'b0;
			done     <= 1'b0;
		end else begin
			done <= busy && (cnt == CW'(1));
			if (start && !busy) begin
				rem      <= '0;
				quotient <= dividend;
				cnt      <= CW'(W);
				busy     <= 1'b1;
			end else if (busy) begin
				rem      <= trial[W] ? {rem[W-1:0], quotient[W-1]} : trial;
				quotient <= {quotient[W-2:0], ~trial[W]};
				cnt      <= cnt - CW'(1);
				busy     <= (cnt != CW'(1));
			end
		end
	end
endmodule : cal_divider
`default_nettype wire

/* File: rtl/crc16_engine.sv */
// byte-wide modbus crc-16 accumulator
// assumes bytes are fed one per enable cycle, clear before each packet
`timescale 1ns/1ps
`default_nettype none
module crc16_engine (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// byte feed
	input  wire logic       clear,
	input  wire logic       enable,
	input  wire logic [7:0] data,
	// result
	output logic      [15:0] crc
);
	import exc_report_pkg::*;
	logic [15:0] next_crc;

	// lsb-first shift, reflected polynomial
	always_comb begin
		next_crc = crc ^ {8'h00, data};
		for (int b = 0; b < 8; b++) begin
			next_crc = next_crc[0] ? ((next_crc >> 1) ^ CRC_POLY) : (next_crc >> 1);
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			crc <= CRC_INIT;
		else if (clear)
			crc <= CRC_INIT;
		else if (enable)
			crc <= next_crc;
	end
endmodule : crc16_engine
`default_nettype wire

/* File: rtl/exc_report_pkg.sv */
// constants shared by the exception reporter and its helpers
// assumes one 200 MHz clock and an avalon-mm host issuing word accesses
//
// Overview of operation
// - exceptions are only reported while modbus mode is selected
// - analog value above high limit sets high exception, packet sent at once
// - high exception clears only below high limit minus dead band
// - analog value below low limit sets low exception, packet sent at once
// - low exception clears only above low limit plus dead band
// - while any exception holds, resend fresh data each retransmit expiry
// - a retransmit time of zero sends each exception exactly once
// - packet is unsolicited, poll-shaped, and no acknowledge is awaited
// - digital packet: address, 02, io high, 01, inputs, crc high, crc low
// - analog packet: address, 04, io high, 08, four words, crc high, low
// - io high byte: 0-15 base unit, 16-31 first expansion module
// - single-point calibration: gain one, offset reference minus acquired
// - two-point calibration: gain is slope, offset is intercept
// - gain and offset are kept in non-volatile storage
package exc_report_pkg;
	localparam int NUM_CH = 4;
	// ****************************************
	// register byte offsets and bank numbers
	// ****************************************
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_SLAVE  = 8'h04;
	localparam logic [7:0] REG_IOHI   = 8'h08;
	localparam logic [7:0] REG_RETX   = 8'h0C;
	localparam logic [7:0] REG_DBAND  = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_MASK   = 8'h18;
	localparam logic [7:0] REG_FLAGS  = 8'h1C;
	localparam logic [7:0] REG_CALCMD = 8'h20;
	localparam logic [7:0] REG_CALP1  = 8'h24;
	localparam logic [7:0] REG_CALP2  = 8'h28;
	localparam logic [3:0] BANK_HI    = 4'h4;
	localparam logic [3:0] BANK_LO    = 4'h5;
	localparam logic [3:0] BANK_GAIN  = 4'h6;
	localparam logic [3:0] BANK_OFFS  = 4'h7;
	// ****************************************
	// field positions and reset values
	// ****************************************
	localparam int CTRL_MODBUS = 0;
	localparam int CTRL_DI_EN  = 1;
	localparam int CAL_TWO_PT  = 2;
	localparam int CAL_START   = 3;
	localparam int CAL_BUSY    = 8;
	localparam int ST_EXC      = 0;
	localparam int ST_SENT     = 1;
	localparam int ST_CAL      = 2;
	localparam logic [15:0] GAIN_ONE  = 16'h0100;
	localparam logic [7:0]  SLAVE_RST = 8'h01;
	localparam logic [15:0] RETX_RST  = 16'h0000;
	// ****************************************
	// packet layout and checksum
	// ****************************************
	localparam logic [7:0]  FC_DIGITAL  = 8'h02;
	localparam logic [7:0]  FC_ANALOG   = 8'h04;
	localparam logic [7:0]  CNT_DIGITAL = 8'h01;
	localparam logic [7:0]  CNT_ANALOG  = 8'h08;
	localparam logic [3:0]  LEN_DIGITAL = 4'h5;
	localparam logic [3:0]  LEN_ANALOG  = 4'hC;
	localparam logic [15:0] CRC_INIT    = 16'hFFFF;
	localparam logic [15:0] CRC_POLY    = 16'hA001;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_NS       = 1000000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
endpackage : exc_report_pkg

/* File: rtl/io_exception_reporter.sv */
// exception reporter: limit watch, packet framer, retransmit and calibration
// assumes avalon-mm host, radio byte sink and nv store on the same clock
`timescale 1ns/1ps
`default_nettype none
module io_exception_reporter #(
	parameter int TICK_CYCLES = exc_report_pkg::TICK_CYCLES
)(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// avalon-mm slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// inputs watched
	input  wire logic [63:0] analog_input_channel,
	input  wire logic [7:0]  discrete_input,
	// packet byte stream to radio
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	// non-volatile calibration store
	output logic             nv_save,
	output logic      [1:0]  nv_channel,
	output logic      [15:0] nv_gain,
	output logic      [15:0] nv_offset,
	input  wire logic        nv_restore_valid,
	input  wire logic [1:0]  nv_restore_channel,
	input  wire logic [15:0] nv_restore_gain,
	input  wire logic [15:0] nv_restore_offset,
	// interrupt
	output logic             irq
);
	import exc_report_pkg::*;
	localparam int DW = $clog2(TICK_CYCLES);

	typedef enum logic {TX_IDLE, TX_RUN} tx_state_e;
	typedef enum logic [1:0] {CAL_IDLE, CAL_DIV, CAL_ICPT, CAL_SAVE} cal_state_e;

	// ****************************************
	// calibration arithmetic
	// ****************************************
	function automatic logic [15:0] apply_cal(input logic [15:0] raw,
		input logic signed [15:0] g, input logic signed [15:0] o);
		logic signed [32:0] p;
		logic signed [33:0] s;
		p = $signed({1'b0, raw}) * g;
		s = 34'(p >>> 8) + 34'(o);
		if (s < 0)
			apply_cal = 16'h0000;
		else if (s > 34'sh0FFFF)
			apply_cal = 16'hFFFF;
		else
			apply_cal = s[15:0];
	endfunction : apply_cal

	logic        acc, modbus, di_en;
	logic [7:0]  slave_addr;
	logic [4:0]  io_hi;
	logic [15:0] retx_ms, dead_band, ref1, acq1, ref2, acq2;
	logic [2:0]  status, mask;
	logic [15:0] hi_lim [NUM_CH];
	logic [15:0] lo_lim [NUM_CH];
	logic signed [15:0] gain [NUM_CH];
	logic signed [15:0] offs [NUM_CH];
	logic [15:0] corr [NUM_CH];
	logic [NUM_CH-1:0] hi_exc, lo_exc, set_hi, set_lo;
	logic [31:0] rd_word;
	logic        cal_busy;

	// ****************************************
	// avalon-mm slave: one wait cycle per access
	// ****************************************
	wire       wr_ok  = write & acc;
	wire [3:0] bank   = address[7:4];
	wire [1:0] ch     = address[3:2];
	wire       w_bank = wr_ok && (bank >= BANK_HI);
	wire [2:0] w1c    = (wr_ok && address == REG_STATUS) ? writedata[2:0] : 3'h0;
	assign waitrequest = (read | write) & ~acc;

	assign rd_word =
		address == REG_CTRL   ? {30'h0, di_en, modbus} :
		address == REG_SLAVE  ? {24'h0, slave_addr} :
		address == REG_IOHI   ? {27'h0, io_hi} :
		address == REG_RETX   ? {16'h0, retx_ms} :
		address == REG_DBAND  ? {16'h0, dead_band} :
		address == REG_STATUS ? {29'h0, status} :
		address == REG_MASK   ? {29'h0, mask} :
		address == REG_FLAGS  ? {24'h0, lo_exc, hi_exc} :
		address == REG_CALCMD ? {23'h0, cal_busy, 8'h00} :
		address == REG_CALP1  ? {ref1, acq1} :
		address == REG_CALP2  ? {ref2, acq2} :
		bank == BANK_HI       ? {16'h0, hi_lim[ch]} :
		bank == BANK_LO       ? {16'h0, lo_lim[ch]} :
		bank == BANK_GAIN     ? {16'h0, gain[ch]} :
		bank == BANK_OFFS     ? {16'h0, offs[ch]} : 32'h0;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			acc      <= 1'b0;
			readdata <= 32'h0;
		end else begin
			acc <= (read | write) & ~acc;
			if (read && !acc)
				readdata <= rd_word;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			modbus     <= 1'b0;
			di_en      <= 1'b0;
			slave_addr <= SLAVE_RST;
			io_hi      <= 5'h00;
			retx_ms    <= RETX_RST;
			dead_band  <= 16'h0000;
			mask       <= 3'h0;
			{ref1, acq1, ref2, acq2} <= 64'h0;
		end else if (wr_ok) begin
			unique case (address)
				REG_CTRL:  {di_en, modbus} <= {writedata[CTRL_DI_EN], writedata[CTRL_MODBUS]};
				REG_SLAVE: slave_addr <= writedata[7:0];
				REG_IOHI:  io_hi <= writedata[4:0];
				REG_RETX:  retx_ms <= writedata[15:0];
				REG_DBAND: dead_band <= writedata[15:0];
				REG_MASK:  mask <= writedata[2:0];
				REG_CALP1: {ref1, acq1} <= writedata;
				REG_CALP2: {ref2, acq2} <= writedata;
				default:   ;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (w_bank && bank == BANK_HI)
			hi_lim[ch] <= writedata[15:0];
		if (w_bank && bank == BANK_LO)
			lo_lim[ch] <= writedata[15:0];
	end

	// ****************************************
	// discrete inputs: pin synchroniser and change watch
	// ****************************************
	logic [7:0] di_meta, di_sync, di_prev;
	wire        di_change = modbus && di_en && (di_sync != di_prev);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			di_meta <= 8'h00;
			di_sync <= 8'h00;
			di_prev <= 8'h00;
		end else begin
			di_meta <= discrete_input;
			di_sync <= di_meta;
			di_prev <= di_sync;
		end
	end

	// ****************************************
	// per-channel correction and limit hysteresis
	// ****************************************
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		logic        h, l;
		wire  [15:0] v       = corr[c];
		wire  [16:0] hi_m_db = {1'b0, hi_lim[c]} - {1'b0, dead_band};
		wire  [16:0] lo_p_db = {1'b0, lo_lim[c]} + {1'b0, dead_band};
		wire         clr_hi  = !hi_m_db[16] && (v < hi_m_db[15:0]);
		wire         clr_lo  = {1'b0, v} > lo_p_db;
		assign set_hi[c] = v > hi_lim[c];
		assign set_lo[c] = v < lo_lim[c];
		assign hi_exc[c] = h;
		assign lo_exc[c] = l;
		always_ff @(posedge sys_clk or negedge reset_n) begin
			if (!reset_n) begin
				corr[c] <= 16'h0000;
				h       <= 1'b0;
				l       <= 1'b0;
			end else begin
				corr[c] <= apply_cal(analog_input_channel[16*c +: 16], gain[c], offs[c]);
				// peer-to-peer mode keeps the watch idle
				if (!modbus) begin
					h <= 1'b0;
					l <= 1'b0;
				end else begin
					if (set_hi[c])
						h <= 1'b1;
					else if (clr_hi)
						h <= 1'b0;
					if (set_lo[c])
						l <= 1'b1;
					else if (clr_lo)
						l <= 1'b0;
				end
			end
		end
	end

	wire new_exc = modbus && |((set_hi & ~hi_exc) | (set_lo & ~lo_exc));
	wire any_exc = |{hi_exc, lo_exc};

	// ****************************************
	// retransmit timer, millisecond ticks
	// ****************************************
	logic [DW-1:0] div_cnt;
	logic [15:0]   retx_cnt;
	wire tick      = (div_cnt == DW'(TICK_CYCLES - 1));
	wire retx_fire = modbus && any_exc && (retx_ms != 16'h0) && tick
		&& (retx_cnt == retx_ms - 16'h1);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt  <= '0;
			retx_cnt <= 16'h0;
		end else begin
			div_cnt <= tick ? '0 : div_cnt + DW'(1);
			if (!any_exc || new_exc || retx_fire)
				retx_cnt <= 16'h0;
			else if (tick)
				retx_cnt <= retx_cnt + 16'h1;
		end
	end

	// ****************************************
	// packet framer
	// ****************************************
	tx_state_e   tx_state;
	logic        ana_pend, dig_pend, is_ana;
	logic [3:0]  idx;
	logic [7:0]  snap_di;
	logic [15:0] snap [NUM_CH];
	wire  [15:0] crc;
	wire  start    = (tx_state == TX_IDLE) && (ana_pend || dig_pend);
	wire  can_load = !tx_valid || tx_ready;
	wire  [3:0] len = is_ana ? LEN_ANALOG : LEN_DIGITAL;
	wire  [3:0] k   = idx - 4'h4;
	wire  [15:0] aw = snap[k[2:1]];
	wire  [7:0] pay_b =
		idx == 4'h0 ? slave_addr :
		idx == 4'h1 ? (is_ana ? FC_ANALOG : FC_DIGITAL) :
		idx == 4'h2 ? {3'h0, io_hi} :
		idx == 4'h3 ? (is_ana ? CNT_ANALOG : CNT_DIGITAL) :
		is_ana ? (k[0] ? aw[7:0] : aw[15:8]) : snap_di;
	wire  [7:0] cur_byte = idx == len ? crc[15:8] :
		idx == len + 4'h1 ? crc[7:0] : pay_b;
	wire  in_run  = tx_state == TX_RUN;
	wire  crc_en  = in_run && can_load && (idx < len);
	wire  sent    = in_run && can_load && (idx == len + 4'h2);

	crc16_engine u_crc (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.clear   (start),
		.enable  (crc_en),
		.data    (cur_byte),
		.crc     (crc)
	);

	// set wins over the taking of a request
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ana_pend <= 1'b0;
			dig_pend <= 1'b0;
		end else begin
			ana_pend <= new_exc || retx_fire || (ana_pend && !(start && ana_pend));
			dig_pend <= di_change || (dig_pend && !(start && !ana_pend));
		end
	end

	// no acknowledge is awaited; the frame just goes out
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_state <= TX_IDLE;
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			idx      <= 4'h0;
			is_ana   <= 1'b0;
			snap_di  <= 8'h00;
		end else begin
			unique case (tx_state)
				TX_IDLE: if (start) begin
					tx_state <= TX_RUN;
					idx      <= 4'h0;
					is_ana   <= ana_pend;
					snap_di  <= di_sync;
				end
				TX_RUN: if (sent) begin
					tx_valid <= 1'b0;
					tx_state <= TX_IDLE;
				end else if (can_load) begin
					tx_data  <= cur_byte;
					tx_valid <= 1'b1;
					idx      <= idx + 4'h1;
				end
			endcase
		end
	end

	// fresh values are captured at the start of every resend
	always_ff @(posedge sys_clk) begin
		if (start)
			snap <= corr;
	end

	// ****************************************
	// calibration sequencer
	// ****************************************
	cal_state_e  cal_state;
	logic [1:0]  cal_ch;
	logic        div_go;
	assign cal_busy = cal_state != CAL_IDLE;
	wire  cal_go   = wr_ok && address == REG_CALCMD && writedata[CAL_START] && !cal_busy;
	wire  [16:0] dref = {1'b0, ref2} - {1'b0, ref1};
	wire  [16:0] dacq = {1'b0, acq2} - {1'b0, acq1};
	wire  [16:0] mref = dref[16] ? -dref : dref;
	wire  [16:0] macq = dacq[16] ? -dacq : dacq;
	wire  neg = dref[16] ^ dacq[16];
	wire  [23:0] quo;
	wire  div_done;
	wire  [15:0] g_mag = |quo[23:15] ? 16'h7FFF : quo[15:0];
	wire  signed [32:0] ap = $signed({1'b0, acq1}) * gain[cal_ch];
	wire  signed [33:0] ic = $signed({18'h0, ref1}) - 34'(ap >>> 8);

	cal_divider #(.W(24)) u_div (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.start    (div_go),
		.dividend ({mref[15:0], 8'h00}),
		.divisor  ({8'h00, macq[15:0]}),
		.busy     (),
		.done     (div_done),
		.quotient (quo)
	);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cal_state <= CAL_IDLE;
			cal_ch    <= 2'h0;
			div_go    <= 1'b0;
		end else begin
			div_go <= 1'b0;
			unique case (cal_state)
				CAL_IDLE: if (cal_go) begin
					cal_ch    <= writedata[1:0];
					div_go    <= writedata[CAL_TWO_PT];
					cal_state <= writedata[CAL_TWO_PT] ? CAL_DIV : CAL_SAVE;
				end
				CAL_DIV:  if (div_done)
					cal_state <= CAL_ICPT;
				CAL_ICPT: cal_state <= CAL_SAVE;
				CAL_SAVE: cal_state <= CAL_IDLE;
			endcase
		end
	end

	// gain and offset survive power loss through the nv store
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < NUM_CH; i++) begin
				gain[i] <= GAIN_ONE;
				offs[i] <= 16'h0000;
			end
		end else if (cal_go && !writedata[CAL_TWO_PT]) begin
			gain[writedata[1:0]] <= GAIN_ONE;
			offs[writedata[1:0]] <= ref1 - acq1;
		end else if (cal_state == CAL_DIV && div_done) begin
			gain[cal_ch] <= neg ? -g_mag : g_mag;
		end else if (cal_state == CAL_ICPT) begin
			offs[cal_ch] <= ic[15:0];
		end else if (nv_restore_valid && !cal_busy) begin
			gain[nv_restore_channel] <= nv_restore_gain;
			offs[nv_restore_channel] <= nv_restore_offset;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			nv_save    <= 1'b0;
			nv_channel <= 2'h0;
			nv_gain    <= GAIN_ONE;
			nv_offset  <= 16'h0000;
		end else begin
			nv_save <= cal_state == CAL_SAVE;
			if (cal_state == CAL_SAVE) begin
				nv_channel <= cal_ch;
				nv_gain    <= gain[cal_ch];
				nv_offset  <= offs[cal_ch];
			end
		end
	end

	// ****************************************
	// interrupt status, write one to clear, set wins
	// ****************************************
	wire [2:0] ev = {cal_state == CAL_SAVE, sent, new_exc};
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			status <= 3'h0;
		else
			status <= (status & ~w1c) | ev;
	end
	assign irq = |(status & mask);

	// ****************************************
	// checks
	// ****************************************
	property p_mode_off;
		@(posedge sys_clk) disable iff (!reset_n)
		!modbus |=> (hi_exc == 4'h0) && (lo_exc == 4'h0);
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("exception held out of modbus mode");

	property p_hi_set;
		@(posedge sys_clk) disable iff (!reset_n)
		modbus && set_hi[0] && !hi_exc[0] |=> hi_exc[0] && ana_pend ##1 ana_pend || tx_state == TX_RUN;
	endproperty
	a_hi_set: assert property (p_hi_set) else $error("high exception not raised");

	property p_hi_hold;
		@(posedge sys_clk) disable iff (!reset_n)
		modbus && hi_exc[0] && !g_ch[0].clr_hi |=> hi_exc[0];
	endproperty
	a_hi_hold: assert property (p_hi_hold) else $error("high exception left inside band");

	property p_lo_set;
		@(posedge sys_clk) disable iff (!reset_n)
		modbus && (corr[0] < lo_lim[0]) |=> lo_exc[0];
	endproperty
	a_lo_set: assert property (p_lo_set) else $error("low exception not raised");

	property p_lo_hold;
		@(posedge sys_clk) disable iff (!reset_n)
		modbus && lo_exc[0] && ({1'b0, corr[0]} <= g_ch[0].lo_p_db) |=> lo_exc[0];
	endproperty
	a_lo_hold: assert property (p_lo_hold) else $error("low exception left inside band");

	property p_retx;
		@(posedge sys_clk) disable iff (!reset_n)
		retx_fire |=> ana_pend;
	endproperty
	a_retx: assert property (p_retx) else $error("retransmit lost");

	property p_once;
		@(posedge sys_clk) disable iff (!reset_n)
		retx_ms == 16'h0 && !new_exc && !ana_pend |=> !ana_pend;
	endproperty
	a_once: assert property (p_once) else $error("retransmit with zero timeout");

	property p_first_byte;
		@(posedge sys_clk) disable iff (!reset_n)
		start |=> ##1 tx_valid && tx_data == $past(slave_addr, 2);
	endproperty
	a_first_byte: assert property (p_first_byte) else $error("packet not led by address");

	property p_single_cal;
		@(posedge sys_clk) disable iff (!reset_n)
		cal_go && !writedata[CAL_TWO_PT] |=> ##1 nv_save && nv_gain == GAIN_ONE;
	endproperty
	a_single_cal: assert property (p_single_cal) else $error("single point gain not one");
endmodule : io_exception_reporter
`default_nettype wire

/* File: tb/io_exception_reporter_tb.sv */
// self-checking bench for the exception reporter
// assumes radio_sink as far side; nv restore path driven by hand
`timescale 1ns/1ps
`default_nettype none
module io_exception_reporter_tb;
	import exc_report_pkg::*;
	logic        sys_clk, reset_n, read, write, waitrequest, irq;
	logic        tx_valid, tx_ready, slow, nv_save, nv_restore_valid;
	logic [7:0]  address, discrete_input, tx_data;
	logic [31:0] writedata, readdata, rd;
	logic [63:0] analog_input_channel;
	logic [1:0]  nv_channel, nv_restore_channel;
	logic [15:0] nv_gain, nv_offset, nv_restore_gain, nv_restore_offset;
	logic [15:0] av[4];
	int          fails, total_checks, cyc;

	io_exception_reporter #(.TICK_CYCLES(50)) io_exception_reporter_i (
		.sys_clk(sys_clk), .reset_n(reset_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .analog_input_channel(analog_input_channel),
		.discrete_input(discrete_input), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .nv_save(nv_save), .nv_channel(nv_channel),
		.nv_gain(nv_gain), .nv_offset(nv_offset), .nv_restore_valid(nv_restore_valid),
		.nv_restore_channel(nv_restore_channel), .nv_restore_gain(nv_restore_gain),
		.nv_restore_offset(nv_restore_offset), .irq(irq));
	radio_sink radio_sink_i (.sys_clk(sys_clk), .reset_n(reset_n), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, got, exp);
		end
	endtask : chk

	// request held until waitrequest sampled low at a rising edge, released there
	task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		address <= a;
		writedata <= d;
		read <= ~w;
		write <= w;
		do @(posedge sys_clk); while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(negedge sys_clk);
	endtask : bus

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c = c ^ {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction : crc16

	task automatic cmp_pkt(input logic [7:0] e[$]);
		logic [15:0] c;
		int          k;
		c = crc16(e);
		e.push_back(c[15:8]);
		e.push_back(c[7:0]);
		for (k = 0; k < 400 && radio_sink_i.pkt.size() < e.size(); k++)
			@(posedge sys_clk);
		foreach (e[i]) chk(radio_sink_i.pkt[i], e[i]);
		radio_sink_i.pkt.delete();
	endtask : cmp_pkt

	task automatic cmp_ana();
		logic [7:0] e[$];
		e = '{8'h01, 8'h04, 8'h10, 8'h08};
		foreach (av[i]) begin
			e.push_back(av[i][15:8]);
			e.push_back(av[i][7:0]);
		end
		cmp_pkt(e);
	endtask : cmp_ana

	// packets already in flight carry stale data, so they are dropped
	task automatic set_ch(input int i, input logic [15:0] v);
		@(posedge sys_clk);
		analog_input_channel[i*16 +: 16] <= v;
		av[i] = v;
		repeat (3) @(posedge sys_clk);
		do @(negedge sys_clk); while (tx_valid !== 1'b0);
		radio_sink_i.pkt.delete();
	endtask : set_ch

	task automatic t_reset();
		bus(0, REG_SLAVE, 0);
		chk(rd, 32'h1);
		bus(0, 8'hFC, 0);
		chk(rd, 32'h0);
		bus(0, {BANK_GAIN, 4'h0}, 0);
		chk(rd, 32'h100);
	endtask : t_reset

	task automatic t_high();
		for (int k = 0; k < 4; k++) begin
			bus(1, {BANK_HI, k[1:0], 2'b00}, 32'h1000);
			bus(1, {BANK_LO, k[1:0], 2'b00}, 32'h0100);
		end
		bus(1, REG_DBAND, 32'h10);
		bus(1, REG_IOHI, 32'h10);
		bus(1, REG_MASK, 32'h1);
		bus(1, REG_CTRL, 32'h1);
		slow <= 1'b1;
		set_ch(0, 16'h2000);
		cmp_ana();
		bus(0, REG_FLAGS, 0);
		chk(rd, 32'h1);
		chk(irq, 1'b1);
		repeat (300) @(posedge sys_clk);
		chk(radio_sink_i.pkt.size(), 0);
		set_ch(0, 16'h0FF8);
		bus(0, REG_FLAGS, 0);
		chk(rd, 32'h1);
		set_ch(0, 16'h0FE0);
		bus(0, REG_FLAGS, 0);
		chk(rd, 32'h0);
		bus(1, REG_MASK, 0);
		chk(irq, 1'b0);
		bus(1, REG_MASK, 1);
		bus(1, REG_STATUS, 32'h7);
		chk(irq, 1'b0);
	endtask : t_high

	task automatic t_low();
		bus(1, REG_RETX, 32'h2);
		slow <= 1'b0;
		set_ch(2, 16'h0050);
		cmp_ana();
		bus(0, REG_FLAGS, 0);
		chk(rd, 32'h40);
		set_ch(2, 16'h0060);
		cmp_ana();
		set_ch(2, 16'h0105);
		bus(0, REG_FLAGS, 0);
		chk(rd, 32'h40);
		set_ch(2, 16'h0120);
		bus(0, REG_FLAGS, 0);
		chk(rd, 32'h0);
		bus(1, REG_RETX, 0);
		set_ch(2, 16'h0120);
	endtask : t_low

	task automatic t_digital();
		bus(1, REG_CTRL, 32'h3);
		@(posedge sys_clk);
		discrete_input <= 8'h0E;
		cmp_pkt('{8'h01, 8'h02, 8'h10, 8'h01, 8'h0E});
	endtask : t_digital

	task automatic t_mode_off();
		bus(1, REG_CTRL, 0);
		@(posedge sys_clk);
		discrete_input <= 8'h01;
		set_ch(1, 16'h3000);
		repeat (300) @(posedge sys_clk);
		chk(radio_sink_i.pkt.size(), 0);
		set_ch(1, 16'h0800);
	endtask : t_mode_off

	task automatic t_cal(input logic [31:0] cmd, p1, p2, input logic [1:0] ch,
		input logic [31:0] exp);
		bus(1, REG_CALP1, p1);
		bus(1, REG_CALP2, p2);
		bus(1, REG_CALCMD, cmd);
		for (int k = 0; k < 99 && nv_save !== 1'b1; k++)
			@(negedge sys_clk);
		chk({nv_gain, nv_offset}, exp);
		chk(nv_channel, ch);
		bus(0, {BANK_GAIN, ch, 2'b00}, 0);
		chk(rd, exp[31:16]);
		bus(0, {BANK_OFFS, ch, 2'b00}, 0);
		chk(rd, exp[15:0]);
	endtask : t_cal

	task automatic t_restore();
		@(posedge sys_clk);
		nv_restore_channel <= 2'h3;
		nv_restore_gain    <= 16'h0123;
		nv_restore_offset  <= 16'h0045;
		nv_restore_valid   <= 1'b1;
		@(posedge sys_clk);
		nv_restore_valid <= 1'b0;
		bus(0, {BANK_GAIN, 4'hC}, 0);
		chk(rd, 32'h0123);
		bus(0, {BANK_OFFS, 4'hC}, 0);
		chk(rd, 32'h0045);
	endtask : t_restore

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// bounds a hang well past the thousand or so cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end

	initial begin
		{reset_n, read, write, address, writedata, discrete_input, slow} = '0;
		{nv_restore_valid, nv_restore_channel, nv_restore_gain, nv_restore_offset} = '0;
		analog_input_channel = {4{16'h0800}};
		av = '{default: 16'h0800};
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_reset();
		t_high();
		t_low();
		t_digital();
		t_mode_off();
		t_cal(32'h9, 32'h0200_0180, 32'h0, 2'h1, 32'h0100_0080);
		t_cal(32'hE, 32'h0180_0080, 32'h0380_0180, 2'h2, 32'h0200_0080);
		t_restore();
		give_verdict();
	end
endmodule : io_exception_reporter_tb
`default_nettype wire

/* File: tb/radio_sink.sv */
// radio byte sink standing in for the master station
// assumes the packet stream shares the reporter clock
`timescale 1ns/1ps
`default_nettype none
module radio_sink (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	// byte stream
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	input  wire logic       slow
);
	logic [7:0] pkt[$];
	logic       ph;
	// stalls every other cycle when slow, to stretch the stream
	assign tx_ready = ~slow | ph;
	// swallows bytes, never answers or acknowledges
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			ph <= 1'b0;
		else begin
			ph <= ~ph;
			if (tx_valid && tx_ready)
				pkt.push_back(tx_data);
		end
	end
endmodule : radio_sink
`default_nettype wire
